// ===== core/dps_device.sv
// Drive device end: power state machine, status word and speed objects.
// Assumes link writes are single-cycle strobes on i_core_clk.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
module dps_device
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   dps_link_if.device link,
   input wire logic [7:0] i_op_mode,
   input wire logic i_fault_detect,
   input wire logic i_fault_clearable,
   input wire logic i_fault_reaction_done,
   input wire logic [31:0] i_error_entry,
   input wire logic i_voltage_present,
   input wire logic i_warning,
   input wire logic i_target_reached,
   input wire logic i_bus_sync,
   input wire logic i_setup_ok,
   input wire logic i_index_seen,
   input wire logic i_open_loop,
   input wire logic i_speed_from_encoder,
   input wire logic [15:0] i_speed_calc,
   input wire logic [15:0] i_speed_encoder,
   input wire logic [15:0] i_speed_min,
   input wire logic [15:0] i_speed_max,
   input wire logic [1:0] i_mode_status,
   output logic o_halt,
   output logic o_power_on,
   output logic [3:0] o_mode_cmd
);
   typedef struct packed {
      dps_pkg::dps_state_e st;
      logic [15:0] cmd;
      logic [15:0] target;
      logic [15:0] demand;
      logic [15:0] measured;
      logic [15:0] fault;
      logic [15:0] sw;
      logic limit;
      logic halt;
      logic power;
      logic [3:0] mode_cmd;
   } dps_dev_s;
   dps_dev_s q_reg, q_next;
   logic [15:0] lo;
   logic halt_mode;

   // Next-state logic
   always_comb
   begin
      q_next = q_reg;
      lo = 16'h0000;
      halt_mode = 1'b0;
      if (link.wr_valid && link.wr_index == dps_pkg::OBJ_COMMAND)
         q_next.cmd = link.wr_data;
      if (link.wr_valid && link.wr_index == dps_pkg::OBJ_TARGET)
         q_next.target = link.wr_data;
      case (q_reg.st)
         dps_pkg::ST_NOT_READY: q_next.st = dps_pkg::ST_SOD;
         dps_pkg::ST_SOD:
            if (q_reg.cmd[dps_pkg::CW_VOLTAGE] &&
                q_reg.cmd[dps_pkg::CW_QUICK_N] &&
                !q_reg.cmd[dps_pkg::CW_SWITCH_ON])
               q_next.st = dps_pkg::ST_READY;
         dps_pkg::ST_READY:
            if (!q_reg.cmd[dps_pkg::CW_VOLTAGE] ||
                !q_reg.cmd[dps_pkg::CW_QUICK_N])
               q_next.st = dps_pkg::ST_SOD;
            else if (q_reg.cmd[dps_pkg::CW_SWITCH_ON])
               q_next.st = dps_pkg::ST_SWITCHED_ON;
         dps_pkg::ST_SWITCHED_ON:
            if (!q_reg.cmd[dps_pkg::CW_VOLTAGE] ||
                !q_reg.cmd[dps_pkg::CW_QUICK_N])
               q_next.st = dps_pkg::ST_SOD;
            else if (!q_reg.cmd[dps_pkg::CW_SWITCH_ON])
               q_next.st = dps_pkg::ST_READY;
            else if (q_reg.cmd[dps_pkg::CW_OPERATION])
               q_next.st = dps_pkg::ST_OP_ENABLED;
         dps_pkg::ST_OP_ENABLED:
            if (!q_reg.cmd[dps_pkg::CW_VOLTAGE])
               q_next.st = dps_pkg::ST_SOD;
            else if (!q_reg.cmd[dps_pkg::CW_QUICK_N])
               q_next.st = dps_pkg::ST_QUICK_STOP;
            else if (!q_reg.cmd[dps_pkg::CW_SWITCH_ON])
               q_next.st = dps_pkg::ST_READY;
            else if (!q_reg.cmd[dps_pkg::CW_OPERATION])
               q_next.st = dps_pkg::ST_SWITCHED_ON;
         dps_pkg::ST_QUICK_STOP:
            // Ramp done is not modelled; leave on voltage drop
            if (!q_reg.cmd[dps_pkg::CW_VOLTAGE])
               q_next.st = dps_pkg::ST_SOD;
         dps_pkg::ST_FAULT_REACTION:
            if (i_fault_reaction_done)
               q_next.st = dps_pkg::ST_FAULT;
         dps_pkg::ST_FAULT:
            if (q_reg.cmd[dps_pkg::CW_CLEAR] && i_fault_clearable &&
                !i_fault_detect)
               q_next.st = dps_pkg::ST_SOD;
         default: q_next.st = dps_pkg::ST_NOT_READY;
      endcase
      if (i_fault_detect && q_reg.st != dps_pkg::ST_FAULT &&
          q_reg.st != dps_pkg::ST_FAULT_REACTION)
         q_next.st = dps_pkg::ST_FAULT_REACTION;
      case (q_reg.st)
         dps_pkg::ST_NOT_READY: lo = 16'h0000;
         dps_pkg::ST_SOD: lo = 16'h0040;
         dps_pkg::ST_READY: lo = 16'h0021;
         dps_pkg::ST_SWITCHED_ON: lo = 16'h0023;
         dps_pkg::ST_OP_ENABLED: lo = 16'h0027;
         dps_pkg::ST_QUICK_STOP: lo = 16'h0007;
         dps_pkg::ST_FAULT_REACTION: lo = 16'h000F;
         dps_pkg::ST_FAULT: lo = 16'h0008;
         default: lo = 16'h0000;
      endcase
      lo[dps_pkg::SW_VOLTAGE] = i_voltage_present;
      lo[dps_pkg::SW_WARN] = i_warning;
      lo[dps_pkg::SW_TARGET] = i_target_reached;
      lo[dps_pkg::SW_LIMIT] = q_reg.limit;
      lo[dps_pkg::SW_SYNC] = i_bus_sync;
      lo[dps_pkg::SW_REMOTE] = 1'b1;
      lo[dps_pkg::SW_MODE_LO +: 2] = i_mode_status;
      lo[dps_pkg::SW_CLOSED] = i_setup_ok & i_index_seen;
      q_next.sw = lo;
      q_next.limit = 1'b1;
      if ($signed(q_reg.target) < $signed(i_speed_min))
         q_next.demand = i_speed_min;
      else if ($signed(q_reg.target) > $signed(i_speed_max))
         q_next.demand = i_speed_max;
      else
      begin
         q_next.demand = q_reg.target;
         q_next.limit = 1'b0;
      end
      if (q_reg.st != dps_pkg::ST_OP_ENABLED)
         q_next.demand = 16'h0000;
      q_next.measured = (i_open_loop && !i_speed_from_encoder) ?
         i_speed_calc : i_speed_encoder;
      q_next.fault = i_error_entry[15:0];
      halt_mode = i_op_mode == dps_pkg::MODE_PP ||
         i_op_mode == dps_pkg::MODE_VL || i_op_mode == dps_pkg::MODE_PV ||
         i_op_mode == dps_pkg::MODE_PT || i_op_mode == dps_pkg::MODE_IP;
      q_next.halt = q_reg.cmd[dps_pkg::CW_HALT] & halt_mode;
      // mode bits 4..6 and 9 passed on
      q_next.mode_cmd = {q_reg.cmd[9], q_reg.cmd[6:4]};
      q_next.power = q_reg.st == dps_pkg::ST_OP_ENABLED ||
         q_reg.st == dps_pkg::ST_QUICK_STOP;
   end

   // State register
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         q_reg <= '0;
         q_reg.st <= dps_pkg::ST_NOT_READY;
         q_reg.target <= dps_pkg::RST_TARGET;
      end
      else
         q_reg <= q_next;
   end

   assign link.cmd_word = q_reg.cmd;
   assign link.state_word = q_reg.sw;
   assign link.fault_code = q_reg.fault;
   assign link.demand = q_reg.demand;
   assign link.measured = q_reg.measured;
   assign link.target = q_reg.target;
   assign o_halt = q_reg.halt;
   assign o_power_on = q_reg.power;
   assign o_mode_cmd = q_reg.mode_cmd;
endmodule : dps_device

// ===== core/dps_pkg.sv
// Constants, types and object map for the drive power state control block.
// Assumes a single 50 MHz core clock and synchronous active-high reset.
// Behaviour
// - Last fault code read-only, low 16 bits
// - Command bit 0 requests switched on
// - Command bit 1 requests voltage enable
// - Command bit 2 low requests quick stop
// - Command bit 3 requests operation enabled
// - Command bit 7 clears error if allowed
// - Command bit 8 halts in listed modes
// - Mode-specific bits follow selected operating mode
// - Status bit 9 always one, remote
// - Status bit 8 follows fieldbus sync
// - Status bit 15 after setup and index
// - Low status bits encode normal power states
// - Low status bits encode quick stop, fault
// - Open loop speed source chosen by config
// - Demanded speed reported as signed read-only
// - Out-of-range speed clamped, status bit 11
package dps_pkg;
   // Object indices
   localparam logic [15:0] OBJ_FAULT_CODE = 16'h603F;
   localparam logic [15:0] OBJ_COMMAND = 16'h6040;
   localparam logic [15:0] OBJ_STATE = 16'h6041;
   localparam logic [15:0] OBJ_TARGET = 16'h6042;
   localparam logic [15:0] OBJ_DEMAND = 16'h6043;
   localparam logic [15:0] OBJ_MEASURED = 16'h6044;
   // Reset values
   localparam logic [15:0] RST_COMMAND = 16'h0000;
   localparam logic [15:0] RST_TARGET = 16'h00C8;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   // Command word bit positions
   localparam int CW_SWITCH_ON = 0;
   localparam int CW_VOLTAGE = 1;
   localparam int CW_QUICK_N = 2;
   localparam int CW_OPERATION = 3;
   localparam int CW_CLEAR = 7;
   localparam int CW_HALT = 8;
   // Status word bit positions
   localparam int SW_WARN = 7;
   localparam int SW_SYNC = 8;
   localparam int SW_REMOTE = 9;
   localparam int SW_TARGET = 10;
   localparam int SW_LIMIT = 11;
   localparam int SW_MODE_LO = 12;
   localparam int SW_CLOSED = 15;
   localparam int SW_VOLTAGE = 4;
   // Operating mode codes (signed 8-bit mode selector)
   localparam logic [7:0] MODE_PP = 8'h01;
   localparam logic [7:0] MODE_VL = 8'h02;
   localparam logic [7:0] MODE_PV = 8'h03;
   localparam logic [7:0] MODE_PT = 8'h04;
   localparam logic [7:0] MODE_IP = 8'h07;
   // Host APB register offsets (byte addresses)
   localparam logic [7:0] HR_CMD = 8'h00;
   localparam logic [7:0] HR_TARGET = 8'h04;
   localparam logic [7:0] HR_STATE = 8'h08;
   localparam logic [7:0] HR_FAULT = 8'h0C;
   localparam logic [7:0] HR_DEMAND = 8'h10;
   localparam logic [7:0] HR_MEASURED = 8'h14;
   localparam logic [7:0] HR_IRQ_STATUS = 8'h18;
   localparam logic [7:0] HR_IRQ_ENABLE = 8'h1C;
   localparam logic [7:0] HR_IRQ_CLEAR = 8'h20;
   localparam int IRQ_W = 3; // 0 state change, 1 fault, 2 limit
   // Power states
   typedef enum logic [2:0] {
      ST_NOT_READY, ST_SOD, ST_READY, ST_SWITCHED_ON,
      ST_OP_ENABLED, ST_QUICK_STOP, ST_FAULT_REACTION, ST_FAULT
   } dps_state_e;
endpackage : dps_pkg

// ===== core/dps_link_if.sv
// Object-access link between drive master and drive device.
// Assumes both ends share i_core_clk; a write lands the cycle it is valid.
`timescale 1ns/1ns
interface dps_link_if;
   logic wr_valid;
   logic [15:0] wr_index;
   logic [15:0] wr_data;
   logic [15:0] cmd_word;
   logic [15:0] state_word;
   logic [15:0] fault_code;
   logic [15:0] demand;
   logic [15:0] measured;
   logic [15:0] target;
   modport master (output wr_valid, output wr_index, output wr_data,
      input cmd_word, input state_word, input fault_code,
      input demand, input measured, input target);
   modport device (input wr_valid, input wr_index, input wr_data,
      output cmd_word, output state_word, output fault_code,
      output demand, output measured, output target);
endinterface : dps_link_if

// ===== core/dps_master.sv
// Master end: APB slave registers that forward commands to the drive.
// Assumes a single clock shared with the device end.
`timescale 1ns/1ns
module dps_master
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   dps_link_if.master link,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_irq
);
   typedef struct packed {
      logic wr_valid;
      logic [15:0] wr_index;
      logic [15:0] wr_data;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [dps_pkg::IRQ_W-1:0] ists;
      logic [dps_pkg::IRQ_W-1:0] ien;
      logic [15:0] last_sw;
      logic irq;
   } dps_mst_s;
   dps_mst_s q_reg, q_next;
   logic acc;
   logic [dps_pkg::IRQ_W-1:0] ev;
   logic [dps_pkg::IRQ_W-1:0] clr;

   // APB access, link writes and sticky events
   always_comb
   begin
      q_next = q_reg;
      acc = i_psel && i_penable && !q_reg.ready;
      clr = '0;
      q_next.wr_valid = 1'b0;
      q_next.ready = acc;
      q_next.err = 1'b0;
      q_next.rdata = 32'h00000000;
      if (acc)
      begin
         case (i_paddr)
            dps_pkg::HR_CMD:
            begin
               q_next.rdata = {16'h0000, link.cmd_word};
               q_next.wr_valid = i_pwrite;
               q_next.wr_index = dps_pkg::OBJ_COMMAND;
               q_next.wr_data = i_pwdata[15:0];
            end
            dps_pkg::HR_TARGET:
            begin
               q_next.rdata = {16'h0000, link.target};
               q_next.wr_valid = i_pwrite;
               q_next.wr_index = dps_pkg::OBJ_TARGET;
               q_next.wr_data = i_pwdata[15:0];
            end
            dps_pkg::HR_STATE: q_next.rdata = {16'h0000, link.state_word};
            dps_pkg::HR_FAULT: q_next.rdata = {16'h0000, link.fault_code};
            dps_pkg::HR_DEMAND: q_next.rdata = {16'h0000, link.demand};
            dps_pkg::HR_MEASURED: q_next.rdata = {16'h0000, link.measured};
            dps_pkg::HR_IRQ_STATUS:
               q_next.rdata = {29'h00000000, q_reg.ists};
            dps_pkg::HR_IRQ_ENABLE:
            begin
               q_next.rdata = {29'h00000000, q_reg.ien};
               if (i_pwrite)
                  q_next.ien = i_pwdata[dps_pkg::IRQ_W-1:0];
            end
            dps_pkg::HR_IRQ_CLEAR:
               if (i_pwrite)
                  clr = i_pwdata[dps_pkg::IRQ_W-1:0];
            default: q_next.err = 1'b1;
         endcase
      end
      // Events: state bits change, fault bit rises, limit bit rises
      q_next.last_sw = link.state_word;
      ev[0] = link.state_word[6:0] != q_reg.last_sw[6:0];
      ev[1] = link.state_word[3] && !q_reg.last_sw[3];
      ev[2] = link.state_word[dps_pkg::SW_LIMIT] &&
         !q_reg.last_sw[dps_pkg::SW_LIMIT];
      // Set wins over clear in the same cycle
      q_next.ists = (q_reg.ists & ~clr) | ev;
      q_next.irq = |(q_next.ists & q_next.ien);
   end

   // State register
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         q_reg <= '0;
      else
         q_reg <= q_next;
   end

   assign link.wr_valid = q_reg.wr_valid;
   assign link.wr_index = q_reg.wr_index;
   assign link.wr_data = q_reg.wr_data;
   assign o_prdata = q_reg.rdata;
   assign o_pready = q_reg.ready;
   assign o_pslverr = q_reg.err;
   assign o_irq = q_reg.irq;
endmodule : dps_master

// ===== tb/dps_chk.sv
// Checker on the link between the master and device ends.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module dps_chk
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic wr_valid,
   input wire logic [15:0] wr_index,
   input wire logic [15:0] wr_data,
   input wire logic [15:0] cmd_word,
   input wire logic [15:0] state_word,
   input wire logic [15:0] target
);
   logic switch_on_disabled_flag, rdy, son, ope, qst;
   // Power state decode from low status bits
   always_comb
   begin
      switch_on_disabled_flag = state_word[6] && state_word[3:0] == 4'h0;
      rdy = state_word[6:5] == 2'b01 && state_word[3:0] == 4'h1;
      son = state_word[6:5] == 2'b01 && state_word[3:0] == 4'h3;
      ope = state_word[6:5] == 2'b01 && state_word[3:0] == 4'h7;
      qst = state_word[6:5] == 2'b00 && state_word[3:0] == 4'h7;
   end
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);
   // Command, then state, then status: three edges at most
   sequence s_rdy; ##[1:3] rdy; endsequence
   sequence s_son; ##[1:3] (son || ope); endsequence
   sequence s_ope; ##[1:3] ope; endsequence
   sequence s_qst; ##[1:3] qst; endsequence
   property p_rdy; switch_on_disabled_flag && cmd_word[2:0] == 3'b110 |-> s_rdy; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_son; rdy && cmd_word[2:0] == 3'b111 |-> s_son; endproperty
   a_son: assert property (p_son) else $error("no switch on");
   property p_ope; son && cmd_word[3:0] == 4'hF |-> s_ope; endproperty
   a_ope: assert property (p_ope) else $error("no enable");
   property p_qst; ope && cmd_word[2:1] == 2'b01 |-> s_qst; endproperty
   a_qst: assert property (p_qst) else $error("no quick stop");
   property p_rem; !$past(i_reset) |-> state_word[9]; endproperty
   a_rem: assert property (p_rem) else $error("remote bit low");
   property p_flt;
      state_word[3] |-> !state_word[6] && state_word[2:0] inside {0, 7};
   endproperty
   a_flt: assert property (p_flt) else $error("bad fault code");
   property p_sod; state_word[6] |-> state_word[3:0] == 4'h0; endproperty
   a_sod: assert property (p_sod) else $error("bad disabled code");
   property p_cmd;
      wr_valid && wr_index == dps_pkg::OBJ_COMMAND |=>
         cmd_word == $past(wr_data);
   endproperty
   a_cmd: assert property (p_cmd) else $error("command lost");
   property p_tgt;
      wr_valid && wr_index == dps_pkg::OBJ_TARGET |=>
         target == $past(wr_data);
   endproperty
   a_tgt: assert property (p_tgt) else $error("target lost");
endmodule : dps_chk

// ===== tb/testbench.sv
// Bench: master and device joined by the link, driven over APB.
// Assumes one 50 MHz clock and synchronous active-high reset.
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, rdata;
   logic prdy, perr, irq, halt, pwon, slverr;
   logic [3:0] mcmd;
   logic flt = 1'b0, clr = 1'b0, rdone = 1'b0, vp = 1'b0, sync = 1'b0;
   logic setup = 1'b0, idx = 1'b0, ol = 1'b0, enc = 1'b0;
   logic [7:0] mode = 8'h01;
   logic [31:0] err = 32'h0;
   logic [15:0] calc = 16'h0, encv = 16'h0, smin = 16'h0, smax = 16'h7FFF;
   int mismatches = 0, total_checks = 0, cyc = 0;
   logic [7:0] ml [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h06};
   dps_link_if link();
   dps_master dps_master_i (.i_core_clk(clk), .i_reset(rst), .link(link),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
      .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
      .o_irq(irq));
   dps_device dps_device_i (.i_core_clk(clk), .i_reset(rst), .link(link),
      .i_op_mode(mode), .i_fault_detect(flt), .i_fault_clearable(clr),
      .i_fault_reaction_done(rdone), .i_error_entry(err),
      .i_voltage_present(vp), .i_warning(1'b0), .i_target_reached(1'b0),
      .i_bus_sync(sync), .i_setup_ok(setup), .i_index_seen(idx),
      .i_open_loop(ol), .i_speed_from_encoder(enc), .i_speed_calc(calc),
      .i_speed_encoder(encv), .i_speed_min(smin), .i_speed_max(smax),
      .i_mode_status(2'b00), .o_halt(halt), .o_power_on(pwon),
      .o_mode_cmd(mcmd));
   dps_chk dps_chk_i (.i_core_clk(clk), .i_reset(rst),
      .wr_valid(link.wr_valid), .wr_index(link.wr_index),
      .wr_data(link.wr_data), .cmd_word(link.cmd_word),
      .state_word(link.state_word), .target(link.target));
   // Clock and a ceiling well above the expected run
   always #10 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         mismatches++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; idle cycle after so psel never toggles twice
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      // Wait for pready; only the cycle ceiling ends a hang
      do
      begin
         @(posedge clk);
      end
      while (prdy !== 1'b1);
      rdata = prd;
      slverr = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wt();
      repeat (4) @(posedge clk);
   endtask : wt
   task automatic rc(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdata & m, e);
   endtask : rc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      wt();
   endtask : wr
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wt();
      rc(dps_pkg::HR_STATE, 32'hFFFF_035F, 32'h0240);
      rc(dps_pkg::HR_TARGET, 32'hFFFF_FFFF, 32'h00C8);
      apb(1'b0, 8'h40, 32'h0);
      chk(slverr, 32'h1);
      wr(dps_pkg::HR_IRQ_ENABLE, 32'h7);
      wr(dps_pkg::HR_CMD, 32'h6);
      rc(dps_pkg::HR_STATE, 32'h6F, 32'h21);
      wr(dps_pkg::HR_CMD, 32'h7);
      rc(dps_pkg::HR_STATE, 32'h6F, 32'h23);
      wr(dps_pkg::HR_CMD, 32'hF);
      rc(dps_pkg::HR_STATE, 32'h6F, 32'h27);
      chk(pwon, 32'h1);
      // Halt only in the listed modes
      foreach (ml[k])
      begin
         mode <= ml[k];
         wr(dps_pkg::HR_CMD, 32'h10F);
         chk(halt, k < 5);
      end
      wr(dps_pkg::HR_CMD, 32'h25F);
      chk(mcmd, 32'hD);
      // Start from clean status so the limit event is seen alone
      wr(dps_pkg::HR_IRQ_CLEAR, 32'h7);
      chk(irq, 32'h0);
      smax <= 16'h0064;
      wt();
      rc(dps_pkg::HR_STATE, 32'h800, 32'h800);
      rc(dps_pkg::HR_DEMAND, 32'hFFFF, 32'h64);
      chk(irq, 32'h1);
      wr(dps_pkg::HR_TARGET, 32'h50);
      rc(dps_pkg::HR_STATE, 32'h800, 32'h0);
      rc(dps_pkg::HR_DEMAND, 32'hFFFF, 32'h50);
      rc(dps_pkg::HR_IRQ_STATUS, 32'h7, 32'h4);
      wr(dps_pkg::HR_IRQ_CLEAR, 32'h7);
      chk(irq, 32'h0);
      {vp, sync, setup, idx} <= 4'hF;
      wt();
      rc(dps_pkg::HR_STATE, 32'h8110, 32'h8110);
      {ol, idx, calc, encv} <= {2'b10, 16'h1234, 16'h4321};
      wt();
      rc(dps_pkg::HR_STATE, 32'h8000, 32'h0);
      rc(dps_pkg::HR_MEASURED, 32'hFFFF, 32'h1234);
      enc <= 1'b1;
      wt();
      rc(dps_pkg::HR_MEASURED, 32'hFFFF, 32'h4321);
      wr(dps_pkg::HR_CMD, 32'hB);
      rc(dps_pkg::HR_STATE, 32'h6F, 32'h07);
      wr(dps_pkg::HR_CMD, 32'h0);
      rc(dps_pkg::HR_STATE, 32'h4F, 32'h40);
      // Fault entry, refused reset, then accepted reset
      {err, flt} <= {32'hABCD_5678, 1'b1};
      wt();
      rc(dps_pkg::HR_STATE, 32'h4F, 32'h0F);
      rdone <= 1'b1;
      wt();
      rc(dps_pkg::HR_STATE, 32'h4F, 32'h08);
      wr(dps_pkg::HR_FAULT, 32'h1111);
      rc(dps_pkg::HR_FAULT, 32'hFFFF_FFFF, 32'h5678);
      rc(dps_pkg::HR_IRQ_STATUS, 32'h2, 32'h2);
      wr(dps_pkg::HR_CMD, 32'h80);
      rc(dps_pkg::HR_STATE, 32'h4F, 32'h08);
      {flt, clr} <= 2'b01;
      wt();
      rc(dps_pkg::HR_STATE, 32'h4F, 32'h40);
      // Mid-run reset restores written objects
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wt();
      rc(dps_pkg::HR_TARGET, 32'hFFFF_FFFF, 32'h00C8);
      rc(dps_pkg::HR_CMD, 32'hFFFF_FFFF, 32'h0000);
      rc(dps_pkg::HR_STATE, 32'h7F, 32'h50);
      end_sim();
   end
endmodule : testbench
